// ==== rtl/acr_pkg.sv ====
// Package of offsets, field layouts and reset values for the channel config bank
package acr_pkg;

    localparam logic [7:0] ACR_PAGE_ZERO        = 8'h00;

    localparam logic [7:0] ACR_OFS_CH1_GAIN_TRIM = 8'h3f;
    localparam logic [7:0] ACR_OFS_CH1_PHASE     = 8'h40;
    localparam logic [7:0] ACR_OFS_CH2_INPUT     = 8'h41;
    localparam logic [7:0] ACR_OFS_CHAN_TWO_ANALOG_GAIN      = 8'h42;
    localparam logic [7:0] ACR_OFS_CH2_VOLUME    = 8'h43;

    localparam logic [7:0] ACR_RST_CH1_GAIN_TRIM = 8'h80;
    localparam logic [7:0] ACR_RST_CH1_PHASE     = 8'h00;
    localparam logic [7:0] ACR_RST_CH2_INPUT     = 8'h00;
    localparam logic [7:0] ACR_RST_CHAN_TWO_ANALOG_GAIN      = 8'h00;
    localparam logic [7:0] ACR_RST_CH2_VOLUME    = 8'hc9;

    // Gain trim field, upper nibble
    localparam int         ACR_TRIM_LSB          = 4;
    localparam int         ACR_TRIM_MSB          = 7;
    localparam logic [3:0] ACR_TRIM_ZERO_CODE    = 4'h8;

    // Input configuration fields
    localparam int         ACR_INTYP_BIT         = 7;
    localparam int         ACR_INSRC_LSB         = 5;
    localparam int         ACR_INSRC_MSB         = 6;
    localparam int         ACR_COUPLE_BIT        = 4;
    localparam int         ACR_IMP_LSB           = 2;
    localparam int         ACR_IMP_MSB           = 3;
    localparam int         ACR_RANGE_EN_BIT      = 0;

    // Analog gain field
    localparam int         ACR_GAIN_LSB          = 2;
    localparam int         ACR_GAIN_MSB          = 7;
    localparam logic [5:0] ACR_GAIN_MAX_CODE     = 6'h2a;

    // Digital volume
    localparam logic [7:0] ACR_VOL_MUTE_CODE     = 8'h00;
    localparam logic [8:0] ACR_VOL_ZERO_CODE     = 9'h0c9;

    typedef enum logic [1:0] {
        ACR_SRC_ANALOG_DIFF,
        ACR_SRC_ANALOG_SE,
        ACR_SRC_PDM,
        ACR_SRC_RESERVED
    } acr_src_t;

    typedef enum logic [1:0] {
        ACR_IMP_2K5,
        ACR_IMP_10K,
        ACR_IMP_20K,
        ACR_IMP_RESERVED
    } acr_imp_t;

endpackage

// ==== rtl/acr_phase_delay.sv ====
// Programmable delay line counted in modulator clock ticks
`timescale 1ns/10ps
module acr_phase_delay #(
    parameter int W     = 1,
    parameter int DEPTH = 256
) (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     tick,
    input  wire logic [$clog2(DEPTH)-1:0] delay,
    input  wire logic [W-1:0]             din,
    output logic      [W-1:0]             dout
);
    localparam int AW = $clog2(DEPTH);

    // Storage has no reset; taps older than the fill point read stale data
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] wptr_nxt;
    logic [W-1:0]  dout_r;
    logic [W-1:0]  dout_nxt;
    logic [AW-1:0] rptr;

    always_comb begin
        rptr     = wptr_r - delay;
        wptr_nxt = wptr_r;
        dout_nxt = dout_r;
        if (tick) begin
            wptr_nxt = wptr_r + 1'b1;
            dout_nxt = (delay == '0) ? din : mem[rptr];
        end
    end

    always_ff @(posedge mclk) begin
        if (tick) begin
            mem[wptr_r] <= din;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wptr_r <= '0;
            dout_r <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            dout_r <= dout_nxt;
        end
    end

    assign dout = dout_r;

endmodule

// ==== rtl/acr_channel_regs.sv ====
// Channel one trim and channel two input configuration register bank
`timescale 1ns/10ps
module acr_channel_regs
    import acr_pkg::*;
#(
    parameter int MOD_W = 1
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [7:0]        reg_page,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic              range_mode_select,
    input  wire logic              mod_tick,
    input  wire logic [MOD_W-1:0]  chan_one_mod_in,
    output logic      [MOD_W-1:0]  chan_one_mod_out,
    input  wire logic [MOD_W-1:0]  chan_two_mod_in,
    input  wire logic              pdm_data_in_first,
    output logic                   pdm_clock_out,
    output logic      [MOD_W-1:0]  chan_two_mod_out,
    output logic signed [3:0]      chan_one_gain_trim,
    output logic                   chan_two_input_type,
    output acr_src_t               chan_two_input_source,
    output logic                   chan_two_gpio_must_release,
    output logic                   chan_two_coupling_select,
    output acr_imp_t               chan_two_impedance_select,
    output logic                   range_enhancer_en,
    output logic                   auto_level_control_en,
    output logic      [5:0]        chan_two_analog_gain,
    output logic                   chan_two_mute,
    output logic signed [8:0]      chan_two_volume
);

    // Register storage
    logic [3:0] trim_r;
    logic [3:0] trim_nxt;
    logic [7:0] phase_r;
    logic [7:0] phase_nxt;
    logic       intyp_r;
    logic       intyp_nxt;
    acr_src_t   src_r;
    acr_src_t   src_nxt;
    logic       couple_r;
    logic       couple_nxt;
    acr_imp_t   imp_r;
    acr_imp_t   imp_nxt;
    logic       range_en_r;
    logic       range_en_nxt;
    logic [5:0] gain_r;
    logic [5:0] gain_nxt;
    logic [7:0] vol_r;
    logic [7:0] vol_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;

    logic       page_hit;
    logic       wr_trim;
    logic       wr_phase;
    logic       wr_input;
    logic       wr_gain;
    logic       wr_vol;

    // Data path state
    logic [MOD_W-1:0] ch2_data_r;
    logic [MOD_W-1:0] ch2_data_nxt;
    logic             pdm_clk_r;
    logic             pdm_clk_nxt;

    // Decoded outputs, registered so no arithmetic reaches the pins
    logic signed [3:0] trim_db_r;
    logic signed [3:0] trim_db_nxt;
    logic              release_r;
    logic              release_nxt;
    logic              dc_r;
    logic              dc_nxt;
    logic              mute_r;
    logic              mute_nxt;
    logic signed [8:0] vol_db_r;
    logic signed [8:0] vol_db_nxt;
    logic              analog_nxt;

    // Reset images of the decodes, worked out from the field reset values
    localparam logic [3:0]        TRIM_RST    = ACR_RST_CH1_GAIN_TRIM[ACR_TRIM_MSB:ACR_TRIM_LSB];
    localparam logic [1:0]        SRC_RST     = ACR_RST_CH2_INPUT[ACR_INSRC_MSB:ACR_INSRC_LSB];
    localparam logic              ANALOG_RST  = (SRC_RST == ACR_SRC_ANALOG_DIFF)
                                                || (SRC_RST == ACR_SRC_ANALOG_SE);
    localparam logic signed [3:0] TRIM_DB_RST = signed'(TRIM_RST - ACR_TRIM_ZERO_CODE);
    localparam logic signed [8:0] VOL_DB_RST  = signed'({1'b0, ACR_RST_CH2_VOLUME}
                                                        - ACR_VOL_ZERO_CODE);

    // Address decode, page zero only
    always_comb begin
        page_hit = (reg_page == ACR_PAGE_ZERO);
        wr_trim  = reg_wr && page_hit && (reg_addr == ACR_OFS_CH1_GAIN_TRIM);
        wr_phase = reg_wr && page_hit && (reg_addr == ACR_OFS_CH1_PHASE);
        wr_input = reg_wr && page_hit && (reg_addr == ACR_OFS_CH2_INPUT);
        wr_gain  = reg_wr && page_hit && (reg_addr == ACR_OFS_CHAN_TWO_ANALOG_GAIN);
        wr_vol   = reg_wr && page_hit && (reg_addr == ACR_OFS_CH2_VOLUME);
    end

    // Register write next state
    always_comb begin
        trim_nxt     = trim_r;
        phase_nxt    = phase_r;
        intyp_nxt    = intyp_r;
        src_nxt      = src_r;
        couple_nxt   = couple_r;
        imp_nxt      = imp_r;
        range_en_nxt = range_en_r;
        gain_nxt     = gain_r;
        vol_nxt      = vol_r;
        if (wr_trim) begin
            trim_nxt = reg_wdata[ACR_TRIM_MSB:ACR_TRIM_LSB];
        end
        if (wr_phase) begin
            phase_nxt = reg_wdata;
        end
        if (wr_input) begin
            intyp_nxt    = reg_wdata[ACR_INTYP_BIT];
            couple_nxt   = reg_wdata[ACR_COUPLE_BIT];
            range_en_nxt = reg_wdata[ACR_RANGE_EN_BIT];
            // Reserved codes keep the old setting rather than reach the front end
            if (acr_src_t'(reg_wdata[ACR_INSRC_MSB:ACR_INSRC_LSB]) != ACR_SRC_RESERVED) begin
                src_nxt = acr_src_t'(reg_wdata[ACR_INSRC_MSB:ACR_INSRC_LSB]);
            end
            if (acr_imp_t'(reg_wdata[ACR_IMP_MSB:ACR_IMP_LSB]) != ACR_IMP_RESERVED) begin
                imp_nxt = acr_imp_t'(reg_wdata[ACR_IMP_MSB:ACR_IMP_LSB]);
            end
        end
        if (wr_gain) begin
            if (reg_wdata[ACR_GAIN_MSB:ACR_GAIN_LSB] <= ACR_GAIN_MAX_CODE) begin
                gain_nxt = reg_wdata[ACR_GAIN_MSB:ACR_GAIN_LSB];
            end
        end
        if (wr_vol) begin
            vol_nxt = reg_wdata;
        end
    end

    // Read mux; reserved bits and unmapped addresses return zero
    always_comb begin
        rvalid_nxt = reg_rd;
        rdata_nxt  = rdata_r;
        if (reg_rd) begin
            rdata_nxt = 8'h00;
            if (page_hit) begin
                case (reg_addr)
                    ACR_OFS_CH1_GAIN_TRIM: begin
                        rdata_nxt = {trim_r, 4'h0};
                    end
                    ACR_OFS_CH1_PHASE: begin
                        rdata_nxt = phase_r;
                    end
                    ACR_OFS_CH2_INPUT: begin
                        rdata_nxt = {intyp_r, src_r, couple_r, imp_r, 1'b0, range_en_r};
                    end
                    ACR_OFS_CHAN_TWO_ANALOG_GAIN: begin
                        rdata_nxt = {gain_r, 2'b00};
                    end
                    ACR_OFS_CH2_VOLUME: begin
                        rdata_nxt = vol_r;
                    end
                    default: begin
                        rdata_nxt = 8'h00;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trim_r     <= ACR_RST_CH1_GAIN_TRIM[ACR_TRIM_MSB:ACR_TRIM_LSB];
            phase_r    <= ACR_RST_CH1_PHASE;
            intyp_r    <= ACR_RST_CH2_INPUT[ACR_INTYP_BIT];
            src_r      <= acr_src_t'(ACR_RST_CH2_INPUT[ACR_INSRC_MSB:ACR_INSRC_LSB]);
            couple_r   <= ACR_RST_CH2_INPUT[ACR_COUPLE_BIT];
            imp_r      <= acr_imp_t'(ACR_RST_CH2_INPUT[ACR_IMP_MSB:ACR_IMP_LSB]);
            range_en_r <= ACR_RST_CH2_INPUT[ACR_RANGE_EN_BIT];
            gain_r     <= ACR_RST_CHAN_TWO_ANALOG_GAIN[ACR_GAIN_MSB:ACR_GAIN_LSB];
            vol_r      <= ACR_RST_CH2_VOLUME;
            rdata_r    <= 8'h00;
            rvalid_r   <= 1'b0;
        end else begin
            trim_r     <= trim_nxt;
            phase_r    <= phase_nxt;
            intyp_r    <= intyp_nxt;
            src_r      <= src_nxt;
            couple_r   <= couple_nxt;
            imp_r      <= imp_nxt;
            range_en_r <= range_en_nxt;
            gain_r     <= gain_nxt;
            vol_r      <= vol_nxt;
            rdata_r    <= rdata_nxt;
            rvalid_r   <= rvalid_nxt;
        end
    end

    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;

    // Channel one phase trim delay line
    acr_phase_delay #(
        .W     (MOD_W),
        .DEPTH (256)
    ) u_ch1_delay (
        .mclk  (mclk),
        .rst   (rst),
        .tick  (mod_tick),
        .delay (phase_r),
        .din   (chan_one_mod_in),
        .dout  (chan_one_mod_out)
    );

    // Channel two source select and PDM clock
    always_comb begin
        ch2_data_nxt = ch2_data_r;
        pdm_clk_nxt  = 1'b0;
        if (src_r == ACR_SRC_PDM) begin
            // Clock toggles per tick; data taken on the falling phase of the pin clock
            pdm_clk_nxt = mod_tick ? ~pdm_clk_r : pdm_clk_r;
            if (mod_tick && pdm_clk_r) begin
                ch2_data_nxt = {{(MOD_W-1){1'b0}}, pdm_data_in_first};
            end
        end else if (mod_tick) begin
            ch2_data_nxt = chan_two_mod_in;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch2_data_r <= '0;
            pdm_clk_r  <= 1'b0;
        end else begin
            ch2_data_r <= ch2_data_nxt;
            pdm_clk_r  <= pdm_clk_nxt;
        end
    end

    assign chan_two_mod_out = ch2_data_r;
    assign pdm_clock_out    = pdm_clk_r;

    // Decodes follow the next values so they move in step with their fields
    always_comb begin
        analog_nxt  = (src_nxt == ACR_SRC_ANALOG_DIFF) || (src_nxt == ACR_SRC_ANALOG_SE);
        trim_db_nxt = signed'(trim_nxt - ACR_TRIM_ZERO_CODE);
        release_nxt = analog_nxt;
        dc_nxt      = couple_nxt && analog_nxt;
        mute_nxt    = (vol_nxt == ACR_VOL_MUTE_CODE);
        vol_db_nxt  = signed'({1'b0, vol_nxt} - ACR_VOL_ZERO_CODE);
    end

    // A few extra flops buy glitch-free decodes for the analog front end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trim_db_r <= TRIM_DB_RST;
            release_r <= ANALOG_RST;
            dc_r      <= ACR_RST_CH2_INPUT[ACR_COUPLE_BIT] && ANALOG_RST;
            mute_r    <= (ACR_RST_CH2_VOLUME == ACR_VOL_MUTE_CODE);
            vol_db_r  <= VOL_DB_RST;
        end else begin
            trim_db_r <= trim_db_nxt;
            release_r <= release_nxt;
            dc_r      <= dc_nxt;
            mute_r    <= mute_nxt;
            vol_db_r  <= vol_db_nxt;
        end
    end

    // Field decodes for the front end and gain stages
    assign chan_one_gain_trim         = trim_db_r;
    assign chan_two_input_type        = intyp_r;
    assign chan_two_input_source      = src_r;
    // Flag for the pin mux; the host still owns turning the GPIO functions off
    assign chan_two_gpio_must_release = release_r;
    assign chan_two_coupling_select   = dc_r;
    assign chan_two_impedance_select  = imp_r;
    // Range enables follow an outside level, so they stay combinational
    assign range_enhancer_en          = range_en_r && !range_mode_select;
    assign auto_level_control_en      = range_en_r && range_mode_select;
    assign chan_two_analog_gain       = gain_r;
    assign chan_two_mute              = mute_r;
    assign chan_two_volume            = vol_db_r;

endmodule

// ==== testbench/acr_channel_regs_chk.sv ====
// Port checks for the channel configuration bank
`timescale 1ns/10ps
module acr_channel_regs_chk
    import acr_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [7:0]  reg_page,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic        reg_rvalid,
    input wire logic        range_mode_select,
    input wire logic        mod_tick,
    input wire logic        pdm_clock_out,
    input wire acr_src_t    chan_two_input_source,
    input wire logic        chan_two_gpio_must_release,
    input wire logic        chan_two_coupling_select,
    input wire logic        range_enhancer_en,
    input wire logic        auto_level_control_en,
    input wire logic [5:0]  chan_two_analog_gain,
    input wire logic        chan_two_mute,
    input wire logic signed [8:0] chan_two_volume
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic     gain_hit;
    acr_src_t src;
    assign src = chan_two_input_source;
    assign gain_hit = reg_wr && reg_page == ACR_PAGE_ZERO && reg_addr == ACR_OFS_CHAN_TWO_ANALOG_GAIN;
    sequence rd_one; reg_rd ##1 !reg_rd; endsequence
    sequence rv_pulse; reg_rvalid ##1 !reg_rvalid; endsequence
    rd_pulse_a: assert property (rd_one |-> rv_pulse)
        else $error("read answer is not one pulse");
    rv_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without request");
    gain_take_a: assert property (gain_hit && reg_wdata[7:2] <= ACR_GAIN_MAX_CODE
        |=> chan_two_analog_gain == $past(reg_wdata[7:2])) else $error("gain not taken");
    gain_keep_a: assert property (gain_hit && reg_wdata[7:2] > ACR_GAIN_MAX_CODE
        |=> $stable(chan_two_analog_gain)) else $error("reserved gain stored");
    mute_code_a: assert property (chan_two_mute == (chan_two_volume == -9'sd201))
        else $error("mute disagrees with volume");
    src_legal_a: assert property (src != ACR_SRC_RESERVED)
        else $error("reserved source held");
    gpio_free_a: assert property (chan_two_gpio_must_release == (src != ACR_SRC_PDM))
        else $error("pin release flag wrong");
    dc_analog_a: assert property (chan_two_coupling_select |-> src != ACR_SRC_PDM)
        else $error("coupling active on digital source");
    range_pick_a: assert property (range_enhancer_en || auto_level_control_en
        |-> auto_level_control_en == range_mode_select && !(range_enhancer_en
        && auto_level_control_en)) else $error("range mode choice wrong");
    pdm_idle_a: assert property (src != ACR_SRC_PDM && $past(src) != ACR_SRC_PDM
        |-> !pdm_clock_out) else $error("pdm clock runs off pdm source");
    pdm_tog_a: assert property ($past(src) == ACR_SRC_PDM && $past(mod_tick)
        |-> pdm_clock_out != $past(pdm_clock_out)) else $error("pdm clock missed a tick");
endmodule

bind acr_channel_regs acr_channel_regs_chk i_acr_channel_regs_chk (.mclk, .rst, .reg_page,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rvalid, .range_mode_select, .mod_tick,
    .pdm_clock_out, .chan_two_input_source, .chan_two_gpio_must_release,
    .chan_two_coupling_select, .range_enhancer_en, .auto_level_control_en,
    .chan_two_analog_gain, .chan_two_mute, .chan_two_volume);

// ==== testbench/acr_host.sv ====
// Host model for the strobed register port
`timescale 1ns/10ps
module acr_host (
    input  wire logic       mclk,
    output logic      [7:0] reg_page,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_page = 8'h00;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_page <= pg;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // Stale data is flipped so nothing leans on a held value
        reg_wdata <= ~d;
        // Return once the written field has settled at the outputs
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_page <= 8'h00;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
endmodule

// ==== testbench/acr_channel_regs_tb.sv ====
// Testbench for the channel configuration bank
`timescale 1ns/10ps
module acr_channel_regs_tb;
    import acr_pkg::*;
    logic       mclk, rst, rsel, tick, c1_in, c2_in, pdm_in, p;
    logic [7:0] pg, addr, wdata, rdata, rv;
    logic       wr, rd, rvalid, c1_out, c2_out, pdm_clk, typ, rel, dc, den, aen, mute;
    logic signed [3:0] trim;
    logic signed [8:0] vol;
    logic [5:0] gain;
    acr_src_t   src;
    acr_imp_t   imp;
    int         miscompares, n_checks, cyc;
    logic [7:0] rst_exp [6] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'hc9, 8'h00};
    int         dl [3] = '{0, 3, 255};

    acr_host i_acr_host (.mclk(mclk), .reg_page(pg), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));
    acr_channel_regs i_acr_channel_regs (.mclk(mclk), .rst(rst), .reg_page(pg),
        .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .range_mode_select(rsel), .mod_tick(tick),
        .chan_one_mod_in(c1_in), .chan_one_mod_out(c1_out), .chan_two_mod_in(c2_in),
        .pdm_data_in_first(pdm_in), .pdm_clock_out(pdm_clk), .chan_two_mod_out(c2_out),
        .chan_one_gain_trim(trim), .chan_two_input_type(typ), .chan_two_input_source(src),
        .chan_two_gpio_must_release(rel), .chan_two_coupling_select(dc),
        .chan_two_impedance_select(imp), .range_enhancer_en(den),
        .auto_level_control_en(aen), .chan_two_analog_gain(gain), .chan_two_mute(mute),
        .chan_two_volume(vol));

    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    task automatic final_report();
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        i_acr_host.rd(a, rv);
        chk(rv, e);
    endtask
    function automatic logic pat(int k);
        return ^(k & 32'h2d);
    endfunction

    // Ceiling well above the few hundred cycles of the sequence
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        {rst, rsel, tick, c1_in, c2_in, pdm_in, cyc} = '0;
        rst = 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rc(8'h3f + 8'(i), rst_exp[i]);
        chk(trim[3:0], 4'h0);
        chk({mute, vol[8:0]}, 10'h000);
        i_acr_host.wr(8'h00, 8'h3f, 8'hff);
        rc(8'h3f, 8'hf0);
        chk(trim[3:0], 4'h7);
        i_acr_host.wr(8'h00, 8'h3f, 8'h00);
        chk(trim[3:0], 4'h8);
        i_acr_host.wr(8'h00, 8'h40, 8'hff);
        rc(8'h40, 8'hff);
        i_acr_host.wr(8'h00, 8'h41, 8'hff);
        rc(8'h41, 8'h91);
        chk({typ, src, dc, imp, den, aen}, 8'h92);
        @(posedge mclk) rsel <= 1'b1;
        @(negedge mclk) chk({den, aen}, 2'h1);
        for (int i = 0; i < 3; i++) begin
            i_acr_host.wr(8'h00, 8'h41, {1'b0, 2'(i), 1'b1, 2'(i), 2'h0});
            chk({src, imp, rel, dc}, {2'(i), 2'(i), i != 2, i != 2});
        end
        rc(8'h41, 8'h58);
        @(posedge mclk) {tick, pdm_in} <= 2'h3;
        repeat (4) @(negedge mclk);
        p = pdm_clk;
        @(negedge mclk) chk({pdm_clk, c2_out}, {~p, 1'b1});
        @(posedge mclk) pdm_in <= 1'b0;
        repeat (4) @(negedge mclk);
        chk(c2_out, 1'b0);
        i_acr_host.wr(8'h00, 8'h41, 8'h00);
        @(posedge mclk) c2_in <= 1'b1;
        repeat (3) @(negedge mclk);
        chk({c2_out, pdm_clk, rel}, 3'h5);
        i_acr_host.wr(8'h00, 8'h42, 8'ha8);
        chk(gain, 6'h2a);
        i_acr_host.wr(8'h00, 8'h42, 8'hac);
        rc(8'h42, 8'ha8);
        i_acr_host.wr(8'h00, 8'h42, 8'h07);
        rc(8'h42, 8'h04);
        chk(gain, 6'h01);
        i_acr_host.wr(8'h01, 8'h43, 8'h00);
        rc(8'h43, 8'hc9);
        i_acr_host.wr(8'h00, 8'h43, 8'h00);
        chk({mute, vol[8:0]}, 10'h337);
        i_acr_host.wr(8'h00, 8'h43, 8'hff);
        chk({mute, vol[8:0]}, 10'h036);
        i_acr_host.wr(8'h00, 8'h44, 8'h55);
        rc(8'h44, 8'h00);
        foreach (dl[j]) begin
            i_acr_host.wr(8'h00, 8'h40, 8'(dl[j]));
            for (int k = 0; k <= dl[j] + 8; k++) begin
                @(posedge mclk) c1_in <= pat(k);
                @(negedge mclk) if (k > dl[j]) chk(c1_out, pat(k - 1 - dl[j]));
            end
        end
        final_report();
    end
endmodule
